// *** common/can_filter_regs.svh ***
// register offsets, field positions and reset values of the filter bank
`ifndef CAN_FILTER_REGS_SVH
`define CAN_FILTER_REGS_SVH

// byte offsets on the register port
`define HALFMODE_LOWER_OFS   8'hf0
`define HALFMODE_UPPER_OFS   8'hf1
`define CFG_PAIR01_OFS       8'hf2
`define CFG_PAIR23_OFS       8'hf3
`define CFG_PAIR45_OFS       8'hf4
`define CFG_PAIR67_OFS       8'hf5
`define STAMP_HIGH_OFS       8'hff

// configuration register: two filters per byte, odd one in the upper nibble
`define CFG_ODD_FIFO_BIT     7
`define CFG_ODD_SCALE_MSB    6
`define CFG_ODD_SCALE_LSB    5
`define CFG_ODD_ON_BIT       4
`define CFG_EVEN_FIFO_BIT    3
`define CFG_EVEN_SCALE_MSB   2
`define CFG_EVEN_SCALE_LSB   1
`define CFG_EVEN_ON_BIT      0

// mode register: filters per register, high bit odd, low bit even
`define MODE_FILTERS_PER_REG 4

// reset values
`define CFG_RESET            8'h00
`define MODE_RESET           8'h00
`define UNMAPPED_READ        8'h00

// timer byte that is stamped
`define STAMP_TIMER_MSB      15
`define STAMP_TIMER_LSB      8

`endif

// *** common/can_filter_pkg.sv ***
// types shared by the acceptance filter configuration bank
package can_filter_pkg;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_t;

   typedef struct packed {
      logic       fifoSelect;
      logic [1:0] scaleField;
      logic       filterOn;
      logic       highHalfListMode;
      logic       lowHalfListMode;
   } filter_settings_t;

   typedef struct packed {
      logic [31:0] idWord;
      logic [31:0] patternId;
      logic [31:0] patternMask;
      logic [2:0]  filterIndex;
      logic        valid;
   } match_req_t;

   typedef struct packed {
      logic       valid;
      logic       fifoSelect;
      logic [2:0] filterIndex;
   } accept_t;

   typedef enum logic [2:0] {
      REG_NONE    = 3'b000,
      REG_MODE_LO = 3'b001,
      REG_MODE_HI = 3'b010,
      REG_CFG     = 3'b011,
      REG_STAMP   = 3'b100
   } reg_sel_t;

endpackage

// *** src/filter_half_compare.sv ***
// one sixteen-bit half of a filter: mask or identifier list comparison
`timescale 1ns/1ns

module filter_half_compare (
   input  wire logic [15:0] idBits,
   input  wire logic [15:0] patternId,
   input  wire logic [15:0] patternMask,
   input  wire logic        listMode,
   output logic             match
);

   logic maskHit;
   logic listHit;

   // a set mask bit demands equality, a clear one leaves the bit out
   assign maskHit = ((idBits ^ patternId) & patternMask) == 16'h0000;
   // in list mode both registers are identifiers: 0 dominant, 1 recessive
   assign listHit = (idBits == patternId) || (idBits == patternMask);
   assign match   = listMode ? listHit : maskHit;

endmodule // filter_half_compare

// *** src/can_acceptance_filter_config.sv ***
// acceptance filter configuration bank, time stamp byte and accept routing
`timescale 1ns/1ns
`include "can_filter_regs.svh"

// Operation
// - on start of frame stamp timer high byte
// - stamp undefined after reset, others zero
// - fifo select bit routes accepted message
// - two-bit scale field per filter
// - activation bit written by software only
// - two filters per configuration register
// - high-half bit: 0 mask, 1 list
// - low-half bit: 0 mask, 1 list
// - four filters per mode register, interleaved
// - hardware never alters configuration or mode bits
// - identifier bit: 0 dominant, 1 recessive
// - mask bit: 1 compare, 0 ignore
module can_acceptance_filter_config #(
   parameter int NUM_FILTERS = 8
) (
   input  wire logic                          mclk,
   input  wire logic                          resetn,
   input  wire can_filter_pkg::reg_req_t      regReq,
   output logic [7:0]                         regRdata,
   input  wire logic [15:0]                   timerValue,
   input  wire logic                          sofDetect,
   input  wire can_filter_pkg::match_req_t    matchReq,
   output can_filter_pkg::accept_t            accept,
   output can_filter_pkg::filter_settings_t [NUM_FILTERS-1:0] filterSettings,
   output logic [15:0]                        mailboxStampPair
);

   localparam int CFG_REGS  = 4;
   localparam int MODE_REGS = 2;

   // the register layout packs exactly eight filters; refuse anything else
   if (NUM_FILTERS != 8) begin : gen_bad_count
      $error("filter bank is laid out for exactly eight filters");
   end

   typedef struct packed {
      logic [CFG_REGS-1:0][7:0]  cfg;
      logic [MODE_REGS-1:0][7:0] mode;
      logic [7:0]                rdata;
      can_filter_pkg::accept_t   accept;
   } state_t;

   state_t state_q;
   state_t state_d;

   // kept apart from the reset struct: the stamp has no reset value
   logic [7:0] stampHigh_q;
   logic [7:0] stampHigh_d;
   logic [7:0] stampLow_q;
   logic [7:0] stampLow_d;

   // decode of the register port address, shared by reads and writes
   function automatic can_filter_pkg::reg_sel_t decode(
      input logic [7:0] addr
   );
      can_filter_pkg::reg_sel_t sel;
      sel = can_filter_pkg::REG_NONE;
      unique case (addr)
         `HALFMODE_LOWER_OFS: sel = can_filter_pkg::REG_MODE_LO;
         `HALFMODE_UPPER_OFS: sel = can_filter_pkg::REG_MODE_HI;
         `CFG_PAIR01_OFS,
         `CFG_PAIR23_OFS,
         `CFG_PAIR45_OFS,
         `CFG_PAIR67_OFS:     sel = can_filter_pkg::REG_CFG;
         `STAMP_HIGH_OFS:     sel = can_filter_pkg::REG_STAMP;
         default:             sel = can_filter_pkg::REG_NONE;
      endcase
      return sel;
   endfunction

   // index of a configuration register inside the bank
   function automatic logic [1:0] cfgIndex(input logic [7:0] addr);
      logic [7:0] diff;
      diff = addr - `CFG_PAIR01_OFS;
      return diff[1:0];
   endfunction

   // unpack one filter's settings from the bank
   function automatic can_filter_pkg::filter_settings_t unpack(
      input logic [CFG_REGS-1:0][7:0]  cfg,
      input logic [MODE_REGS-1:0][7:0] mode,
      input logic [2:0]                n
   );
      can_filter_pkg::filter_settings_t s;
      logic [7:0] c;
      logic [7:0] m;
      logic [2:0] hiPos;
      logic [2:0] loPos;
      c = cfg[n[2:1]];
      m = mode[n[2]];
      loPos = {n[1:0], 1'b0};
      hiPos = {n[1:0], 1'b1};
      if (n[0]) begin
         s.fifoSelect = c[`CFG_ODD_FIFO_BIT];
         s.scaleField = c[`CFG_ODD_SCALE_MSB:`CFG_ODD_SCALE_LSB];
         s.filterOn   = c[`CFG_ODD_ON_BIT];
      end else begin
         s.fifoSelect = c[`CFG_EVEN_FIFO_BIT];
         s.scaleField = c[`CFG_EVEN_SCALE_MSB:`CFG_EVEN_SCALE_LSB];
         s.filterOn   = c[`CFG_EVEN_ON_BIT];
      end
      s.highHalfListMode = m[hiPos];
      s.lowHalfListMode  = m[loPos];
      return s;
   endfunction

   // matching of the candidate against the selected filter's pattern
   can_filter_pkg::filter_settings_t selSettings;
   logic                             hiMatch;
   logic                             loMatch;

   assign selSettings = unpack(state_q.cfg, state_q.mode,
                               matchReq.filterIndex);

   filter_half_compare highHalf (
      .idBits      (matchReq.idWord[31:16]),
      .patternId   (matchReq.patternId[31:16]),
      .patternMask (matchReq.patternMask[31:16]),
      .listMode    (selSettings.highHalfListMode),
      .match       (hiMatch)
   );

   filter_half_compare lowHalf (
      .idBits      (matchReq.idWord[15:0]),
      .patternId   (matchReq.patternId[15:0]),
      .patternMask (matchReq.patternMask[15:0]),
      .listMode    (selSettings.lowHalfListMode),
      .match       (loMatch)
   );

   can_filter_pkg::reg_sel_t wrSel;
   can_filter_pkg::reg_sel_t rdSel;

   assign wrSel = decode(regReq.addr);
   assign rdSel = wrSel;

   always_comb begin
      state_d = state_q;

      // only the register port writes the bank; no hardware path sets it
      if (regReq.wr) begin
         unique case (wrSel)
            can_filter_pkg::REG_MODE_LO: state_d.mode[0] = regReq.wdata;
            can_filter_pkg::REG_MODE_HI: state_d.mode[1] = regReq.wdata;
            can_filter_pkg::REG_CFG:
               state_d.cfg[cfgIndex(regReq.addr)] = regReq.wdata;
            can_filter_pkg::REG_STAMP,
            can_filter_pkg::REG_NONE: ;
         endcase
      end

      // read data stands only in the cycle after the strobe
      state_d.rdata = `UNMAPPED_READ;
      if (regReq.rd) begin
         unique case (rdSel)
            can_filter_pkg::REG_MODE_LO: state_d.rdata = state_q.mode[0];
            can_filter_pkg::REG_MODE_HI: state_d.rdata = state_q.mode[1];
            can_filter_pkg::REG_CFG:
               state_d.rdata = state_q.cfg[cfgIndex(regReq.addr)];
            can_filter_pkg::REG_STAMP:   state_d.rdata = stampHigh_q;
            can_filter_pkg::REG_NONE:    state_d.rdata = `UNMAPPED_READ;
         endcase
      end

      // scale is exported for the datapath; halves here are 16 bits apiece
      state_d.accept.valid = matchReq.valid && selSettings.filterOn
                             && hiMatch && loMatch;
      state_d.accept.fifoSelect  = selSettings.fifoSelect;
      state_d.accept.filterIndex = matchReq.filterIndex;
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_q.cfg    <= {CFG_REGS{`CFG_RESET}};
         state_q.mode   <= {MODE_REGS{`MODE_RESET}};
         state_q.rdata  <= `UNMAPPED_READ;
         state_q.accept <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   // start of frame takes priority over a software write in the same cycle
   always_comb begin
      stampHigh_d = stampHigh_q;
      stampLow_d  = stampLow_q;
      if (sofDetect) begin
         stampHigh_d = timerValue[`STAMP_TIMER_MSB:`STAMP_TIMER_LSB];
         stampLow_d  = timerValue[`STAMP_TIMER_LSB-1:0];
      end else if (regReq.wr && wrSel == can_filter_pkg::REG_STAMP) begin
         stampHigh_d = regReq.wdata;
      end
   end

   // no reset: the stamp is undefined until the first frame; a write sets only the high byte
   always_ff @(posedge mclk) begin
      stampHigh_q <= stampHigh_d;
      stampLow_q  <= stampLow_d;
   end

   // settings leave straight from the configuration flops
   always_comb begin
      for (int n = 0; n < NUM_FILTERS; n++) begin
         filterSettings[n] = unpack(state_q.cfg, state_q.mode,
                                    3'(n));
      end
   end

   assign regRdata         = state_q.rdata;
   assign accept           = state_q.accept;
   assign mailboxStampPair = {stampHigh_q, stampLow_q};

endmodule // can_acceptance_filter_config

// *** dv/can_filter_monitor.sv ***
// assertion checker for the filter configuration bank
`timescale 1ns/1ns
module can_filter_monitor #(
   parameter int NUM_FILTERS = 8
) (
   input wire logic                       mclk,
   input wire logic                       resetn,
   input wire can_filter_pkg::reg_req_t   regReq,
   input wire logic [7:0]                 regRdata,
   input wire logic [15:0]                timerValue,
   input wire logic                       sofDetect,
   input wire can_filter_pkg::match_req_t matchReq,
   input wire can_filter_pkg::accept_t    accept,
   input wire can_filter_pkg::filter_settings_t [NUM_FILTERS-1:0]
                                          filterSettings,
   input wire logic [15:0]                mailboxStampPair
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   chk_stamp_load: assert property (
      sofDetect |=> mailboxStampPair == $past(timerValue))
      else $error("stamp not loaded from timer");
   chk_rdata_idle: assert property (!$past(regReq.rd) |-> regRdata == 8'h00)
      else $error("read data outside read answer");
   chk_cfg_read: assert property (
      regReq.rd && regReq.addr == 8'hf2 |=> regRdata ==
      $past({filterSettings[1][5:2], filterSettings[0][5:2]}))
      else $error("config pair readback mismatch");
   chk_cfg_hold: assert property (
      !regReq.wr |=> $stable(filterSettings))
      else $error("settings changed without write");
   chk_mode_lower: assert property (
      regReq.wr && regReq.addr == 8'hf0 |=>
      filterSettings[3].highHalfListMode == $past(regReq.wdata[7]) &&
      filterSettings[0].lowHalfListMode == $past(regReq.wdata[0]))
      else $error("lower mode bits misplaced");
   chk_off_reject: assert property (
      matchReq.valid && !filterSettings[matchReq.filterIndex].filterOn
      |=> !accept.valid)
      else $error("inactive filter accepted");
   chk_accept_fifo: assert property (
      matchReq.valid |=> accept.fifoSelect ==
      $past(filterSettings[matchReq.filterIndex].fifoSelect) &&
      accept.filterIndex == $past(matchReq.filterIndex))
      else $error("accept routing mismatch");
   chk_accept_lone: assert property (!matchReq.valid |=> !accept.valid)
      else $error("accept without request");
endmodule // can_filter_monitor

bind can_acceptance_filter_config can_filter_monitor #(
   .NUM_FILTERS(NUM_FILTERS)
) can_filter_monitor_inst (.mclk, .resetn, .regReq, .regRdata,
   .timerValue, .sofDetect, .matchReq, .accept, .filterSettings,
   .mailboxStampPair);

// *** dv/can_acceptance_filter_config_test.sv ***
// self-checking testbench of the filter configuration bank
`timescale 1ns/1ns
`define CHK(n, e, s) begin cmpCount++; if ((s) !== (e)) begin errCount++; \
   $display("wrong value %s exp %h got %h", n, e, s); end end
module can_acceptance_filter_config_test;
   logic                                   mclk;
   logic                                   resetn;
   logic                                   sofDetect;
   logic [7:0]                             regRdata;
   logic [15:0]                            timerValue;
   logic [15:0]                            mailboxStampPair;
   can_filter_pkg::reg_req_t               regReq;
   can_filter_pkg::match_req_t             matchReq;
   can_filter_pkg::accept_t                accept;
   can_filter_pkg::filter_settings_t [7:0] filterSettings;
   logic [7:0]                             cfg [4];
   logic [7:0]                             mode [2];
   int                                     errCount;
   int                                     cmpCount;

   can_acceptance_filter_config #(.NUM_FILTERS(8))
      can_acceptance_filter_config_inst (.mclk, .resetn, .regReq,
      .regRdata, .timerValue, .sofDetect, .matchReq, .accept,
      .filterSettings, .mailboxStampPair);

   task automatic wrReg(logic [7:0] a, d);
      @(posedge mclk);
      regReq <= '{a, d, 1'b1, 1'b0};
      @(posedge mclk);
      regReq.wr <= 1'b0;
   endtask
   task automatic rdReg(logic [7:0] a, e);
      @(posedge mclk);
      regReq <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge mclk);
      regReq.rd <= 1'b0;
      #1 `CHK("regRdata", e, regRdata)
   endtask
   // random register write; slot 6 is unmapped so it must read back 0
   task automatic rndReg();
      logic [7:0] d;
      int a;
      d = $urandom;
      a = $urandom_range(6);
      wrReg(8'(8'hf0 + a), d);
      if (a < 2) mode[a] = d;
      else if (a < 6) cfg[a - 2] = d;
      rdReg(8'(8'hf0 + a), a < 6 ? d : 8'h00);
   endtask
   function automatic can_filter_pkg::filter_settings_t expS(int n);
      logic [7:0] c;
      logic [7:0] m;
      c = cfg[n / 2] >> (4 * (n % 2));
      m = mode[n / 4] >> (2 * (n % 4));
      return {c[3:0], m[1:0]};
   endfunction
   function automatic logic hp(logic [15:0] i, p, k, logic l);
      return l ? (i == p || i == k) : ((i ^ p) & k) == 16'h0000;
   endfunction
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmpCount, errCount);
      if (errCount == 0 && cmpCount > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   initial begin
      repeat (100000) @(posedge mclk);
      errCount++;
      give_verdict();
   end
   initial begin
      logic [15:0] t;
      can_filter_pkg::match_req_t q;
      can_filter_pkg::filter_settings_t s;
      logic acc;
      resetn = 1'b0;
      regReq = '0;
      matchReq = '0;
      sofDetect = 1'b0;
      timerValue = 16'h0000;
      cfg = '{default: 8'h00};
      mode = '{default: 8'h00};
      void'($urandom(32'hd57ba328));
      repeat (8) @(posedge mclk);
      resetn <= 1'b1;
      for (int a = 0; a < 7; a++) rdReg(8'(8'hf0 + a), 8'h00);
      `CHK("settings", 48'h0, filterSettings)
      $display("test reset values done");
      for (int i = 0; i < 60; i++) begin
         // bank takes every write here except to unmapped slot 6: fifo, scale, activation and mode bits may change
         rndReg();
         for (int n = 0; n < 8; n++)
            `CHK("setting", expS(n), filterSettings[n])
      end
      $display("test register map done");
      for (int i = 0; i < 8; i++) begin
         t = $urandom;
         @(posedge mclk);
         timerValue <= t;
         sofDetect <= 1'b1;
         @(posedge mclk);
         sofDetect <= 1'b0;
         #1 `CHK("stamp", t, mailboxStampPair)
         rdReg(8'hff, t[15:8]);
         wrReg(8'hff, ~t[15:8]);
         rdReg(8'hff, ~t[15:8]);
      end
      $display("test time stamp done");
      for (int i = 0; i < 400; i++) begin
         // patterns ride on each request, so no pattern write meets an
         // active filter
         if (i % 8 == 0) rndReg();
         q.patternId = $urandom;
         q.patternMask = $urandom;
         case ($urandom_range(3))
            0: q.idWord = q.patternId;
            1: q.idWord = q.patternMask;
            2: q.idWord = q.patternId ^ ($urandom & ~q.patternMask);
            default: q.idWord = $urandom;
         endcase
         q.filterIndex = $urandom;
         q.valid = 1'b1;
         s = expS(q.filterIndex);
         acc = s.filterOn && hp(q.idWord[31:16], q.patternId[31:16],
            q.patternMask[31:16], s.highHalfListMode) && hp(q.idWord[15:0],
            q.patternId[15:0], q.patternMask[15:0], s.lowHalfListMode);
         @(posedge mclk);
         matchReq <= q;
         @(posedge mclk);
         matchReq.valid <= 1'b0;
         #1 `CHK("accept", acc, accept.valid)
         if (acc)
            `CHK("route", {s.fifoSelect, q.filterIndex},
               {accept.fifoSelect, accept.filterIndex})
      end
      $display("test matching done");
      give_verdict();
   end
endmodule // can_acceptance_filter_config_test
